// >>> asc_sequence_control.sv
// Converter sequence control with AXI4-Lite register slave
//
// How it works
// - Channel code is special bit above four channel bits, from start reg.
// - Result width selectable as 8, 10 or 12 bits.
// - Sequence length field 1..15, zero meaning sixteen conversions.
// - Any of sixteen analog channels may be routed to the converter.
// - Single or continuous sequence, on one channel or several channels.
// - Multi-channel index wraps back to channel zero at the wrap channel.
// - Each result compared, higher-than or less-or-equal; match may interrupt.
// - External trigger from any channel pin or four extra trigger inputs.
// - Results stored left or right justified per configuration bit.
// - Converter returned to low power when a sequence finishes.
// - Stop without internal clock aborts sequence; restarted after stop exit.
// - Restarted sequence acts like a fresh start, clearing complete, done and overrun flags.
// - With internal clock option, sequence runs on through stop mode.
// - Conversion spanning run/stop change is discarded, no flag, no compare.
// - Wait mode behaves like run mode; software may abort first.
// - Freeze: continue, finish current conversion, or stop, per two bits.
// - Each channel pin readable as digital input or usable as trigger.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_sequence_control
  import asc_pkg::*;
#(
  parameter int NCH = 16
) (
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // AXI4-Lite write address and data
  input  wire logic            i_awvalid,
  output logic                 o_awready,
  input  wire logic [11:0]     i_awaddr,
  input  wire logic            i_wvalid,
  output logic                 o_wready,
  input  wire logic [31:0]     i_wdata,
  input  wire logic [3:0]      i_wstrb,
  // AXI4-Lite write response
  output logic                 o_bvalid,
  input  wire logic            i_bready,
  output logic [1:0]           o_bresp,
  // AXI4-Lite read
  input  wire logic            i_arvalid,
  output logic                 o_arready,
  input  wire logic [11:0]     i_araddr,
  output logic                 o_rvalid,
  input  wire logic            i_rready,
  output logic [31:0]          o_rdata,
  output logic [1:0]           o_rresp,
  // Analog converter
  output asc_conv_req_t        o_conv,
  input  wire asc_conv_ans_t   i_conv,
  // Pins, triggers and system modes
  input  wire logic [NCH-1:0]  i_pin_level,
  input  wire logic [3:0]      i_extra_trig,
  input  wire logic            i_stop_mode,
  input  wire logic            i_freeze_mode,
  // Status outputs
  output logic                 o_low_power,
  output logic                 o_use_internal_clock,
  output logic                 o_irq
);
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [3:0]       wrap_ch;
  logic [7:0]       trig_cfg;
  logic [7:0]       trig_int;
  logic [7:0]       seq_cfg;
  logic [6:0]       start_ctl;
  logic [NCH-1:0]   cmp_en;
  logic [NCH-1:0]   ccf;
  logic [NCH-1:0]   dig_en;
  logic [NCH-1:0]   cmp_ht;
  logic [15:0]      cmp_val;
  logic [2:0]       irq_stat;
  logic [2:0]       irq_mask;
  logic             seq_done;
  logic             overrun;
  logic [15:0]      result [NCH];

  asc_state_t       state;
  logic [3:0]       slot;
  logic [3:0]       chan;
  logic             aborted;
  logic             stop_at_start;
  logic             trig_prev;

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  logic             aw_have;
  logic             w_have;
  logic [9:0]       waddr;
  logic [31:0]      wdata;
  logic [3:0]       wstrb;
  logic             wr_fire;
  logic [15:0]      wr_cur;
  logic [15:0]      wr_mask;
  logic [15:0]      wr_val;
  logic             wr_ok;
  logic [15:0]      rd_val;
  logic             rd_ok;

  assign wr_fire = aw_have & w_have & ~o_bvalid;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_awready <= 1'b0;
      aw_have   <= 1'b0;
      waddr     <= 10'h000;
    end else if (i_awvalid && o_awready) begin
      o_awready <= 1'b0;
      aw_have   <= 1'b1;
      waddr     <= i_awaddr[11:2];
    end else if (wr_fire) begin
      aw_have   <= 1'b0;
    end else if (!aw_have && !o_bvalid) begin
      o_awready <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wready <= 1'b0;
      w_have   <= 1'b0;
      wdata    <= 32'h0000_0000;
      wstrb    <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      o_wready <= 1'b0;
      w_have   <= 1'b1;
      wdata    <= i_wdata;
      wstrb    <= i_wstrb;
    end else if (wr_fire) begin
      w_have   <= 1'b0;
    end else if (!w_have && !o_bvalid) begin
      o_wready <= 1'b1;
    end
  end

  // Register readback, shared by reads and by partial-strobe writes
  function automatic logic [16:0] reg_read(input logic [9:0] a);
    logic [16:0] v;
    v = {1'b1, 16'h0000};
    case (a)
      10'(`ASC_IDX_WRAP):    v[3:0] = wrap_ch;
      10'(`ASC_IDX_TRIGCFG): v[7:0] = trig_cfg;
      10'(`ASC_IDX_TRIGINT): v[7:0] = trig_int;
      10'(`ASC_IDX_SEQCFG):  v[7:0] = seq_cfg;
      10'(`ASC_IDX_START):   v[6:0] = start_ctl;
      10'(`ASC_IDX_STATUS):  v[7:0] = {seq_done, 1'b0, overrun, 1'b0, slot};
      10'(`ASC_IDX_CMPEN):   v[15:0] = cmp_en;
      10'(`ASC_IDX_CCF):     v[15:0] = ccf;
      10'(`ASC_IDX_DIGEN):   v[15:0] = dig_en;
      10'(`ASC_IDX_CMPHT):   v[15:0] = cmp_ht;
      10'(`ASC_IDX_CMPVAL):  v[15:0] = cmp_val;
      10'(`ASC_IDX_IRQSTAT): v[2:0] = irq_stat;
      10'(`ASC_IDX_IRQMASK): v[2:0] = irq_mask;
      10'(`ASC_IDX_PORTIN):  v[15:0] = i_pin_level & dig_en;
      default: begin
        if (a >= 10'(`ASC_IDX_RESULT0) &&
            a <  10'(`ASC_IDX_RESULT0 + 2 * NCH) && !a[0])
          v[15:0] = result[4'((a - 10'(`ASC_IDX_RESULT0)) >> 1)];
        else
          v[16] = 1'b0;
      end
    endcase
    return v;
  endfunction : reg_read

  always_comb begin
    {wr_ok, wr_cur} = reg_read(waddr);
    wr_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}};
    wr_val  = (wr_cur & ~wr_mask) | (wdata[15:0] & wr_mask);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_bvalid <= 1'b0;
      o_bresp  <= 2'h0;
    end else if (wr_fire) begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_ok ? 2'h0 : 2'h2;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  always_comb {rd_ok, rd_val} = reg_read(i_araddr[11:2]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= {16'h0000, rd_val};
      o_rresp   <= rd_ok ? 2'h0 : 2'h2;
    end else if (o_rvalid) begin
      if (i_rready) o_rvalid <= 1'b0;
    end else begin
      o_arready <= 1'b1;
    end
  end

  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_fire && waddr == 10'(idx);
  endfunction : wr_hit

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wrap_ch   <= `ASC_RST_WRAP;
      trig_cfg  <= `ASC_RST_TRIGCFG;
      trig_int  <= `ASC_RST_TRIGINT;
      seq_cfg   <= `ASC_RST_SEQCFG;
      start_ctl <= `ASC_RST_START;
      cmp_en    <= '0;
      dig_en    <= '0;
      cmp_ht    <= '0;
      cmp_val   <= `ASC_RST_CMPVAL;
      irq_mask  <= `ASC_RST_IRQMASK;
    end else begin
      if (wr_hit(`ASC_IDX_WRAP))    wrap_ch   <= wr_val[3:0];
      if (wr_hit(`ASC_IDX_TRIGCFG)) trig_cfg  <= wr_val[7:0];
      if (wr_hit(`ASC_IDX_TRIGINT)) trig_int  <= {2'h0, wr_val[5:2], 2'h0};
      if (wr_hit(`ASC_IDX_SEQCFG))  seq_cfg   <= wr_val[7:0];
      if (wr_hit(`ASC_IDX_START))   start_ctl <= wr_val[6:0];
      if (wr_hit(`ASC_IDX_CMPEN))   cmp_en    <= wr_val;
      if (wr_hit(`ASC_IDX_DIGEN))   dig_en    <= wr_val;
      if (wr_hit(`ASC_IDX_CMPHT))   cmp_ht    <= wr_val;
      if (wr_hit(`ASC_IDX_CMPVAL))  cmp_val   <= wr_val;
      if (wr_hit(`ASC_IDX_IRQMASK)) irq_mask  <= wr_val[2:0];
    end
  end

  // --------------------------------------------------------------------
  // Trigger, hold conditions and conversion result
  // --------------------------------------------------------------------
  logic        trig_en;
  logic        trig_raw;
  logic        trig_lvl;
  logic        trig_fire;
  logic        internal_converter_clock_stop;
  logic        stop_abort;
  logic        frz_halt;
  logic        frz_drop;
  logic        start_req;
  logic        restart;
  logic        conv_keep;
  logic        last;
  logic [3:0]  len_m1;
  logic [3:0]  next_chan;
  logic [15:0] justified;
  logic        cmp_match;

  assign trig_en   = trig_int[`ASC_TRIG_EN_BIT];
  assign internal_converter_clock_stop = trig_int[`ASC_INTERNAL_CONVERTER_CLOCK_BIT];
  assign trig_raw  = trig_cfg[`ASC_TRIG_EXTRA_BIT] ?
                     i_extra_trig[trig_cfg[1:0]] : i_pin_level[trig_cfg[3:0]];
  assign trig_lvl  = trig_raw ~^ trig_int[`ASC_TRIG_POL_BIT];
  assign trig_fire = trig_int[`ASC_TRIG_LEVEL_BIT] ? trig_lvl
                                                   : trig_lvl & ~trig_prev;
  assign stop_abort = i_stop_mode & ~internal_converter_clock_stop;
  assign frz_halt  = i_freeze_mode & seq_cfg[1];
  assign frz_drop  = i_freeze_mode & (seq_cfg[1:0] == 2'h3);
  assign start_req = wr_hit(`ASC_IDX_START);
  assign restart   = aborted & ~i_stop_mode;
  assign conv_keep = (stop_at_start == i_stop_mode) & ~frz_drop;
  assign len_m1    = seq_cfg[6:3] - 4'h1;
  assign last      = slot == len_m1;
  assign next_chan = !start_ctl[`ASC_MULT_BIT] ? chan :
                     (chan == wrap_ch) ? 4'h0 : chan + 4'h1;

  always_comb begin
    case (asc_res_t'(trig_cfg[`ASC_RES_LSB +: 2]))
      ASC_RES_8:  justified = {8'h00, i_conv.data[11:4]};
      ASC_RES_10: justified = {6'h00, i_conv.data[11:2]};
      default:    justified = {4'h0, i_conv.data};
    endcase
    if (seq_cfg[`ASC_LEFT_JUST_BIT]) begin
      case (asc_res_t'(trig_cfg[`ASC_RES_LSB +: 2]))
        ASC_RES_8:  justified = {justified[7:0], 8'h00};
        ASC_RES_10: justified = {justified[9:0], 6'h00};
        default:    justified = {justified[11:0], 4'h0};
      endcase
    end
    cmp_match = cmp_ht[slot] ? (justified > cmp_val)
                             : (justified <= cmp_val);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) trig_prev <= 1'b0;
    else          trig_prev <= trig_lvl;
  end

  // --------------------------------------------------------------------
  // Sequence engine
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state         <= ASC_IDLE;
      slot          <= 4'h0;
      chan          <= 4'h0;
      aborted       <= 1'b0;
      stop_at_start <= 1'b0;
    end else if (start_req || restart) begin
      state   <= trig_en ? ASC_ARMED : ASC_ISSUE;
      slot    <= 4'h0;
      chan    <= start_req ? wr_val[3:0] : start_ctl[3:0];
      aborted <= 1'b0;
    end else if (stop_abort && state != ASC_IDLE) begin
      state   <= ASC_IDLE;
      aborted <= 1'b1;
    end else begin
      case (state)
        ASC_ARMED: if (trig_fire) state <= ASC_ISSUE;
        ASC_ISSUE: begin
          if (!frz_halt) begin
            state         <= ASC_BUSY;
            stop_at_start <= i_stop_mode;
          end
        end
        ASC_BUSY: begin
          if (i_conv.done) begin
            slot <= last ? 4'h0 : slot + 4'h1;
            chan <= last ? start_ctl[3:0] : next_chan;
            if (!last)
              state <= ASC_ISSUE;
            else if (start_ctl[`ASC_SCAN_BIT])
              state <= trig_en ? ASC_ARMED : ASC_ISSUE;
            else
              state <= ASC_IDLE;
          end
        end
        default: state <= state;
      endcase
    end
  end

  // Converter request, one-cycle start pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_conv <= '0;
    end else begin
      o_conv.start   <= state == ASC_ISSUE && !frz_halt && !stop_abort
                        && !start_req && !restart;
      o_conv.channel <= {start_ctl[`ASC_SPECIAL_BIT], chan};
      o_conv.res     <= asc_res_t'(trig_cfg[`ASC_RES_LSB +: 2]);
    end
  end

  // --------------------------------------------------------------------
  // Results, flags and interrupt
  // --------------------------------------------------------------------
  logic store;
  logic seq_end;
  logic ovr_ev;

  assign store   = state == ASC_BUSY && i_conv.done && !start_req
                   && !restart && !stop_abort && conv_keep;
  assign seq_end = store && last;
  assign ovr_ev  = trig_en && trig_fire && state != ASC_IDLE
                   && state != ASC_ARMED;

  always_ff @(posedge i_clk) begin
    if (store) result[slot] <= justified;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ccf      <= '0;
      seq_done <= 1'b0;
      overrun  <= 1'b0;
    end else if (start_req || restart) begin
      ccf      <= '0;
      seq_done <= 1'b0;
      overrun  <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (store && slot == 4'(i) && (!cmp_en[i] || cmp_match))
          ccf[i] <= 1'b1;
        else if (wr_hit(`ASC_IDX_CCF) && wr_val[i])
          ccf[i] <= 1'b0;
      end
      if (seq_end)
        seq_done <= 1'b1;
      else if (wr_hit(`ASC_IDX_STATUS) && wr_val[`ASC_SEQ_DONE_BIT])
        seq_done <= 1'b0;
      if (ovr_ev)
        overrun <= 1'b1;
      else if (wr_hit(`ASC_IDX_STATUS) && wr_val[`ASC_OVERRUN_BIT])
        overrun <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat <= 3'h0;
    end else begin
      irq_stat <= (irq_stat &
                   ~(wr_hit(`ASC_IDX_IRQSTAT) ? wr_val[2:0] : 3'h0)) |
                  {ovr_ev, store && cmp_en[slot] && cmp_match,
                   seq_end};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq                <= 1'b0;
      o_low_power          <= 1'b1;
      o_use_internal_clock <= 1'b0;
    end else begin
      o_irq                <= |(irq_stat & irq_mask);
      o_low_power          <= state == ASC_IDLE;
      o_use_internal_clock <= i_stop_mode & internal_converter_clock_stop
                              & (state != ASC_IDLE);
    end
  end
endmodule : asc_sequence_control

// >>> asc_regs.svh
// Register offsets, field positions and reset values of the sequence control
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ASC_IDX_WRAP        8'h00
`define ASC_IDX_TRIGCFG     8'h01
`define ASC_IDX_TRIGINT     8'h02
`define ASC_IDX_SEQCFG      8'h03
`define ASC_IDX_START       8'h05
`define ASC_IDX_STATUS      8'h06
`define ASC_IDX_CMPEN       8'h08
`define ASC_IDX_CCF         8'h0A
`define ASC_IDX_DIGEN       8'h0C
`define ASC_IDX_CMPHT       8'h0E
`define ASC_IDX_RESULT0     8'h10
`define ASC_IDX_CMPVAL      8'h40
`define ASC_IDX_IRQSTAT     8'h41
`define ASC_IDX_IRQMASK     8'h42
`define ASC_IDX_PORTIN      8'h43
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASC_TRIG_EXTRA_BIT  7
`define ASC_RES_LSB         5
`define ASC_INTERNAL_CONVERTER_CLOCK_BIT        5
`define ASC_TRIG_LEVEL_BIT  4
`define ASC_TRIG_POL_BIT    3
`define ASC_TRIG_EN_BIT     2
`define ASC_LEFT_JUST_BIT   7
`define ASC_LEN_LSB         3
`define ASC_SPECIAL_BIT     6
`define ASC_SCAN_BIT        5
`define ASC_MULT_BIT        4
`define ASC_SEQ_DONE_BIT    7
`define ASC_OVERRUN_BIT     5
`define ASC_IRQ_SEQ         0
`define ASC_IRQ_CMP         1
`define ASC_IRQ_OVR         2
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASC_RST_WRAP        4'hF
`define ASC_RST_TRIGCFG     8'h0F
`define ASC_RST_TRIGINT     8'h00
`define ASC_RST_SEQCFG      8'h20
`define ASC_RST_START       7'h00
`define ASC_RST_CMPVAL      16'h0000
`define ASC_RST_IRQMASK     3'h0
`endif

// >>> asc_pkg.sv
// Types shared by the converter sequence control
package asc_pkg;
  typedef enum logic [2:0] {
    ASC_IDLE,
    ASC_ARMED,
    ASC_ISSUE,
    ASC_BUSY
  } asc_state_t;

  typedef enum logic [1:0] {
    ASC_RES_8  = 2'h0,
    ASC_RES_10 = 2'h1,
    ASC_RES_12 = 2'h2,
    ASC_RES_12B = 2'h3
  } asc_res_t;

  // Request to the analog converter
  typedef struct packed {
    logic       start;
    logic [4:0] channel;
    asc_res_t   res;
  } asc_conv_req_t;

  // Answer from the analog converter
  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } asc_conv_ans_t;
endpackage : asc_pkg

// >>> asc_adc_model.sv
// Behavioural analog converter answering conversion requests
`timescale 1ns/1ps
module asc_adc_model
  import asc_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire asc_conv_req_t i_req,
  input  wire logic [7:0]    i_delay,
  output asc_conv_ans_t      o_ans
);
  logic [7:0] cnt;
  logic [4:0] ch;
  // Data lines toggle outside the done pulse so stale values never match
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt   <= 8'h00;
      ch    <= 5'h00;
      o_ans <= '0;
    end else begin
      o_ans.done <= 1'b0;
      o_ans.data <= ~o_ans.data;
      if (i_req.start) begin
        cnt <= i_delay + 8'h01;
        ch  <= i_req.channel;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        if (cnt == 8'h01) begin
          o_ans <= {1'b1, 3'h5, ch, 4'hC};
        end
      end
    end
  end
endmodule : asc_adc_model

// >>> asc_sequence_control_assertions.sv
// Port checks of the converter sequence control
`timescale 1ns/1ps
module asc_sequence_control_checker
  import asc_pkg::*;
(
  input wire logic          i_clk, i_rst_n,
  input wire logic          i_awvalid, o_awready, i_wvalid, o_wready,
  input wire logic          o_bvalid, i_bready, i_arvalid, o_arready,
  input wire logic          o_rvalid, i_rready, i_stop_mode,
  input wire logic          o_low_power, o_use_internal_clock,
  input wire logic [31:0]   o_rdata,
  input wire asc_conv_req_t o_conv
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ------------------------------------------------------------
  // Sequences
  // ------------------------------------------------------------
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_start;
    o_conv.start;
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_WR_ANSWER:
    assert property (s_wr_taken |-> ##[1:3] o_bvalid)
    else $error("write response missing");
  AST_WR_ONCE:
    assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response repeated");
  AST_RD_ANSWER:
    assert property (s_rd_taken |-> ##[1:2]
      (o_rvalid && o_rdata[31:16] == 16'h0000))
    else $error("read answer missing or upper half set");
  AST_RD_ONCE:
    assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer repeated");
  AST_RD_REFUSE:
    assert property (o_rvalid |-> !o_arready)
    else $error("read address accepted while answering");
  AST_START_GAP:
    assert property (s_start |=> !o_conv.start)
    else $error("conversion requests too close");
  AST_START_AWAKE:
    assert property (s_start |-> !o_low_power)
    else $error("conversion requested while in low power");
  AST_STOP_HALT:
    assert property (o_conv.start && $past(i_stop_mode)
      |-> o_use_internal_clock)
    else $error("conversion requested in stop without internal clock");
endmodule : asc_sequence_control_checker

bind asc_sequence_control asc_sequence_control_checker u_asc_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
  .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready),
  .i_stop_mode(i_stop_mode), .o_low_power(o_low_power),
  .o_use_internal_clock(o_use_internal_clock), .o_rdata(o_rdata),
  .o_conv(o_conv));

// >>> testbench.sv
// Self-checking bench for the converter sequence control
`timescale 1ns/1ps
module testbench;
  import asc_pkg::*;
  logic          i_clk, i_rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic          stop, awready, wready, bvalid, arready, rvalid, lp, irq;
  logic          frz, uic;
  logic [11:0]   awaddr, araddr, d;
  logic [31:0]   wdata, rdata;
  logic [15:0]   pins;
  logic [3:0]    etrig;
  logic [7:0]    dly;
  logic [4:0]    c;
  logic [1:0]    rresp, bresp;
  logic [1:0]    b_q[$];
  asc_conv_req_t conv;
  asc_conv_ans_t ans;
  logic [33:0]   rd_q[$];
  logic [4:0]    ch_q[$];
  int            error_cnt, n_compared, seed, n_start, tgt, k, i;

  initial i_clk = 1'b0;
  always #5 i_clk = ~i_clk;

  asc_sequence_control u_asc_sequence_control (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'h3),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
    .o_rresp(rresp), .o_conv(conv), .i_conv(ans), .i_pin_level(pins),
    .i_extra_trig(etrig), .i_stop_mode(stop), .i_freeze_mode(frz),
    .o_low_power(lp), .o_use_internal_clock(uic), .o_irq(irq));

  asc_adc_model u_asc_adc_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_req(conv), .i_delay(dly), .o_ans(ans));

  // ------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic tmo(input int n);
    if (n >= 400) begin
      error_cnt++;
      end_sim();
    end
  endtask : tmo

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    int n;
    n = 0;
    b_q.push_back(a == 12'hFFC ? 2'h2 : 2'h0);
    @(posedge i_clk);
    awaddr  <= a;
    wdata   <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 400);
    bready <= 1'b0;
    tmo(n);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n;
    n = 0;
    rd_q.push_back(e);
    @(posedge i_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 400);
    rready <= 1'b0;
    tmo(n);
  endtask : rd

  task automatic wait_ev(input int t, input logic need_lp);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (!(n_start >= t && (lp || !need_lp)) && n < 400);
    tmo(n);
  endtask : wait_ev

  // Oldest expectation is taken whenever a result appears
  always @(posedge i_clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rd_q.pop_front());
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, b_q.pop_front()});
    if (conv.start) begin
      n_start++;
      chk({29'h0, conv.channel}, {29'h0, ch_q.pop_front()});
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    seed = 8;
    i_rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, stop, frz} = '0;
    {awaddr, araddr, wdata, etrig, dly} = '0;
    pins = 16'($random(seed));
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(12'h000, 34'h0000F);
    rd(12'h004, 34'h0000F);
    rd(12'h00C, 34'h00020);
    rd(12'hFFC, {2'b10, 32'h0});
    wr(12'hFFC, 16'h0000);
    wr(12'h030, 16'h00FF);
    rd(12'h10C, {18'h0, pins & 16'h00FF});
    wr(12'h004, 16'h0040);
    wr(12'h108, 16'h0001);
    for (k = 0; k < 2; k++) begin
      c = 5'($random(seed) & 15);
      dly <= 8'($random(seed) & 7);
      d = {3'h5, c, 4'hC};
      ch_q.push_back(c);
      wr(12'h00C, {8'h00, k[0], 7'h08});
      wr(12'h014, {11'h000, c});
      tgt++;
      wait_ev(tgt, 1'b1);
      rd(12'h040, k ? {18'h0, d, 4'h0} : {22'h0, d});
      rd(12'h104, 34'h1);
      chk({33'h0, irq}, 34'h1);
      wr(12'h104, 16'h0001);
      rd(12'h028, 34'h1);
      chk({33'h0, irq}, 34'h0);
    end
    // Sixteen conversions wrapping after channel 5, compare both ways
    wr(12'h000, 16'h0005);
    wr(12'h00C, 16'h0000);
    wr(12'h020, 16'hFFFF);
    wr(12'h100, 16'h0A4C);
    for (k = 0; k < 2; k++) begin
      wr(12'h038, {16{~k[0]}});
      for (i = 0; i < 16; i++) ch_q.push_back(5'((3 + i) % 6));
      wr(12'h014, 16'h0013);
      tgt += 16;
      wait_ev(tgt, 1'b1);
      for (i = 0; i < 16; i++) begin
        rd(12'h040 + 12'(8 * i), {25'h5, 5'((3 + i) % 6), 4'hC});
      end
      rd(12'h028, k ? 34'h0BEFB : 34'h04104);
      rd(12'h104, 34'h3);
      wr(12'h104, 16'h0003);
    end
    // Stop mode in mid conversion aborts, then the sequence restarts
    wr(12'h020, 16'h0000);
    wr(12'h00C, 16'h0008);
    dly <= 8'h28;
    ch_q.push_back(5'h07);
    ch_q.push_back(5'h07);
    wr(12'h014, 16'h0007);
    tgt++;
    wait_ev(tgt, 1'b0);
    stop <= 1'b1;
    repeat (60) @(posedge i_clk);
    stop <= 1'b0;
    tgt++;
    wait_ev(tgt, 1'b1);
    rd(12'h040, 34'h00A7C);
    rd(12'h028, 34'h1);
    // Rising edge on extra trigger input 2 starts the armed sequence
    wr(12'h004, 16'h00C2);
    wr(12'h008, 16'h000C);
    wr(12'h014, 16'h0009);
    chk(34'(n_start), 34'(tgt));
    ch_q.push_back(5'h09);
    etrig <= 4'h4;
    tgt++;
    wait_ev(tgt, 1'b1);
    etrig <= 4'h0;
    rd(12'h040, 34'h00A9C);
    // Freeze with finish-then-hold keeps the next conversion back
    wr(12'h008, 16'h0020);
    frz <= 1'b1;
    wr(12'h00C, 16'h000A);
    ch_q.push_back(5'h07);
    wr(12'h014, 16'h0007);
    repeat (20) @(posedge i_clk);
    chk(34'(n_start), 34'(tgt));
    frz <= 1'b0;
    tgt++;
    wait_ev(tgt, 1'b1);
    // Internal clock: run-to-stop conversion is dropped, no flag
    ch_q.push_back(5'h09);
    wr(12'h014, 16'h0009);
    tgt++;
    wait_ev(tgt, 1'b0);
    stop <= 1'b1;
    repeat (5) @(posedge i_clk);
    chk({33'h0, uic}, 34'h1);
    repeat (55) @(posedge i_clk);
    stop <= 1'b0;
    repeat (20) @(posedge i_clk);
    rd(12'h028, 34'h0);
    rd(12'h040, 34'h00A7C);
    end_sim();
  end
endmodule : testbench
